// file: design/ccsc_pkg.sv
// Package for the coulomb counter and sleep control block.
// Assumes a 100 MHz core clock; all timing counts derive from it.

package ccsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIME_TICK_NS = 878_900_000;
    localparam int TICK_CYCLES_DEF = TIME_TICK_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 27;
    localparam int TICK_W = 12;
    localparam int HOUR_TICKS = 4096;
    localparam int IDLE_W = 13;
    localparam int SLOW_DIV = 256;
    localparam int SLOW_W = 8;
    localparam int SD_SUB_TICKS = 512;
    localparam int SD_SUB_W = 9;

    // ------------------------------------------------------------
    // Counters, temperature bands and thresholds
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int SD_ACC_W = 6;
    localparam int SD_T_FIRST = 5;
    localparam int SD_T_STEP = 10;
    localparam int SD_BANDS = 6;
    localparam int MAG_W = 3;
    localparam int THR_STEPS = 8;
    localparam logic [2:0] WAKE_SEL_RST = 3'h7;
    localparam logic SLEEP_ALLOW_RST = 1'b1;

    // Clear request bit positions.
    localparam int CLR_DISCH = 0;
    localparam int CLR_CHG = 1;
    localparam int CLR_SELF = 2;
    localparam int CLR_DTIME = 3;
    localparam int CLR_CTIME = 4;
    localparam int CLR_W = 5;

    // Synchroniser vector layout.
    localparam int SY_MAG = 0;
    localparam int SY_NEG = 3;
    localparam int SY_CONV = 4;
    localparam int SY_PACK = 5;
    localparam int SY_WIRE = 6;
    localparam int SY_W = 7;
    localparam logic [SY_W-1:0] SYNC_RST = 7'h60;
    localparam logic [2:0] PREV_RST = 3'h6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {PWR_AWAKE = 1'b0, PWR_ASLEEP = 1'b1} ccsc_pwr_t;

    typedef struct packed {
        logic [CNT_W-1:0] discharge_count;
        logic [CNT_W-1:0] charge_count;
        logic [CNT_W-1:0] self_discharge_count;
        logic [CNT_W-1:0] discharge_time_count;
        logic [CNT_W-1:0] charge_time_count;
    } ccsc_counts_t;

    typedef struct packed {
        logic sleep_allow;
        logic charge_timer_slow_flag;
        logic discharge_timer_slow_flag;
        logic [2:0] wake_threshold_select;
    } ccsc_mode_t;

    typedef struct packed {
        ccsc_counts_t counts;
        ccsc_mode_t mode;
        logic [CLR_W-1:0] clr_pend;
        ccsc_pwr_t pwr;
        logic fell_asleep;
        logic [PRE_W-1:0] pre;
        logic [TICK_W-1:0] tick;
        logic [IDLE_W-1:0] idle;
        logic [SD_ACC_W-1:0] sd_acc;
        logic [7:0] temp;
        logic [SY_W-1:0] sy1;
        logic [SY_W-1:0] sy2;
        logic [2:0] prev;
        logic cal;
        logic stat_oe;
    } ccsc_state_t;

    localparam ccsc_state_t STATE_RST = '{
        counts: '0,
        mode: '{sleep_allow: SLEEP_ALLOW_RST, charge_timer_slow_flag: 1'b0,
                discharge_timer_slow_flag: 1'b0, wake_threshold_select: WAKE_SEL_RST},
        clr_pend: '0, pwr: PWR_AWAKE, fell_asleep: 1'b0, pre: '0, tick: '0,
        idle: '0, sd_acc: '0, temp: '0, sy1: SYNC_RST, sy2: SYNC_RST,
        prev: PREV_RST, cal: 1'b0, stat_oe: 1'b0
    };

endpackage

// file: design/ccsc_top.sv
// Coulomb counter, elapsed-time counters, self-discharge counter and
// sleep control, all in one module with a single state struct.
// Assumes converter pulses, sense sign and magnitude, the bus line and
// pack detect come from pins; temperature and host strobes are on CORE_CLK.
//
// Summary of operation
// - Negative sense: each converter quantum bumps discharge count; charge count holds.
// - Discharge indicated, flag clear: discharge time counter advances each 0.8789 s tick.
// - Positive sense: each converter quantum bumps charge count; discharge count holds.
// - Charge indicated, flag clear: charge time counter advances each 0.8789 s tick.
// - Time counters are 16 bits, wrap, and a wrap sets their slow flag.
// - With slow flag set the time counter advances at 1/256 rate.
// - Self-discharge counts once an hour at 25 C, doubling per 10 C up to 55 C.
// - Below 25 C the self-discharge rate halves per 10 C, floor below 5 C.
// - Sleep keeps only self-discharge and temperature updating.
// - Sleep when current below threshold, sleep allowed, bus idle one hour.
// - Any bus line edge wakes the asleep device while pack detect is high.
// - Reset sets sleep allow to one.
// - Wake select: 0 none, 1..7 pick 21.35 down to 3.05 uV; default 7.
// - Pack detect falling forces sleep regardless of sleep allow.
// - Pack detect rise wakes if allow is zero or device was awake at fall.
// - Pack detect rise does not wake if allow set and asleep at fall.
// - Offset recalibration pulses once every hour without host action.
// - A clear request sets its pending bit; the next edge zeroes its counter and returns that bit to zero together.
// - Clearing a time counter also clears its slow flag.
// - Pack detect low turns off the open-drain status output on the third clock edge after the pin falls.

`timescale 1ns/1ps

module ccsc_top
    import ccsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CONV_PULSE,
    input wire logic SENSE_NEG,
    input wire logic [MAG_W-1:0] SENSE_MAG,
    input wire logic ONE_WIRE_LINE_I,
    input wire logic PACK_DETECT_IN,
    input wire logic [7:0] TEMP_C,
    input wire logic [CLR_W-1:0] CLR_REQ,
    input wire logic MODE_WE,
    input wire logic SLEEP_ALLOW_WR,
    input wire logic [2:0] WAKE_SEL_WR,
    input wire logic STAT_LEVEL,
    output ccsc_counts_t COUNTS,
    output ccsc_mode_t MODE,
    output logic [CLR_W-1:0] CLR_PENDING,
    output logic [7:0] TEMPERATURE,
    output logic ASLEEP,
    output logic OFFSET_CAL,
    output logic STAT_O,
    output logic STAT_OE
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------

    // The prescaler must fit its field and divide by at least two.
    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << PRE_W)) begin : g_bad_tick
        $error("TICK_CYCLES out of range for the prescaler");
    end

    // The tick counter must wrap exactly once per hour for the calibration strobe.
    if ((1 << TICK_W) != HOUR_TICKS) begin : g_bad_hour
        $error("TICK_W does not span one hour of ticks");
    end

    // The slow rate and self-discharge strobes decode low bits of the tick counter.
    if ((1 << SLOW_W) != SLOW_DIV || (1 << SD_SUB_W) != SD_SUB_TICKS ||
        SD_SUB_W > TICK_W || SLOW_W > TICK_W) begin : g_bad_div
        $error("Slow divider or self-discharge period does not fit the tick counter");
    end

    // The idle counter must hold the full hour count without wrapping.
    if (HOUR_TICKS >= (1 << IDLE_W)) begin : g_bad_idle
        $error("IDLE_W too narrow for one hour of ticks");
    end

    // The threshold arithmetic assumes a three bit magnitude and eight steps.
    if (MAG_W != 3 || THR_STEPS != 8) begin : g_bad_thr
        $error("Magnitude width and threshold steps disagree");
    end

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------

    // Returns one when the sensed magnitude lies below the wake threshold.
    // Code k selects (8-k) steps of 3.05 uV; code zero disables the test.
    function automatic logic below_thr(input logic [2:0] sel,
                                       input logic [MAG_W-1:0] mag);
        logic [3:0] lim;
        lim = 4'(THR_STEPS) - {1'b0, sel};
        below_thr = (sel != 3'h0) && ({1'b0, mag} < lim);
    endfunction

    // Picks the strobe that advances a time counter: every tick normally,
    // every 256th tick once its slow flag is set.
    function automatic logic time_step(input logic slow, input logic fast_stb,
                                       input logic slow_stb);
        time_step = slow ? slow_stb : fast_stb;
    endfunction

    // Returns the self-discharge weight in 1/64 counts per eighth hour.
    // Eight is one count per hour at the reference band around 25 C.
    function automatic logic [6:0] sd_weight(input logic signed [7:0] t);
        int k;
        k = 0;
        for (int i = 0; i < SD_BANDS; i++) begin
            if (int'(t) >= SD_T_FIRST + i * SD_T_STEP) begin
                k = k + 1;
            end
        end
        sd_weight = 7'(1 << k);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ccsc_state_t q;
    ccsc_state_t d;

    // Edge strobes from the synchronised pins.
    logic conv_rise;
    logic pack_fall;
    logic pack_rise;
    logic wire_edge;

    // Synchronised pin levels.
    logic pack_high;
    logic neg;
    logic [MAG_W-1:0] mag;
    logic nonzero;

    // Timebase strobes.
    logic tick;
    logic slow_tick;
    logic sd_tick;
    logic hour;

    // Power and bus idle status.
    logic awake;
    logic idle_hour;

    // Time counter and accumulator arithmetic.
    logic dt_wrap;
    logic ct_wrap;
    logic [CNT_W:0] dt_sum;
    logic [CNT_W:0] ct_sum;
    logic [SD_ACC_W:0] sd_sum;

    // Edges and levels, read only from the second synchroniser stage.
    // History resets to the idle pin levels, so releasing reset gives no false edge.
    assign neg = q.sy2[SY_NEG];
    assign mag = q.sy2[SY_MAG +: MAG_W];
    assign nonzero = mag != '0;
    assign pack_high = q.sy2[SY_PACK];
    assign conv_rise = q.sy2[SY_CONV] & ~q.prev[0];
    assign pack_fall = ~q.sy2[SY_PACK] & q.prev[1];
    assign pack_rise = q.sy2[SY_PACK] & ~q.prev[1];
    assign wire_edge = q.sy2[SY_WIRE] ^ q.prev[2];

    // Timebase strobes derived from the free running prescaler and tick counter.
    assign tick = q.pre == PRE_W'(TICK_CYCLES - 1);
    assign slow_tick = tick && (q.tick[SLOW_W-1:0] == SLOW_W'(SLOW_DIV - 1));
    assign sd_tick = tick && (q.tick[SD_SUB_W-1:0] == SD_SUB_W'(SD_SUB_TICKS - 1));
    assign hour = tick && (q.tick == TICK_W'(HOUR_TICKS - 1));
    assign awake = q.pwr == PWR_AWAKE;
    assign idle_hour = q.idle == IDLE_W'(HOUR_TICKS);

    // Time counter sums, with the carry marking a wrap past all ones.
    assign dt_sum = {1'b0, q.counts.discharge_time_count} + 17'h00001;
    assign ct_sum = {1'b0, q.counts.charge_time_count} + 17'h00001;
    assign sd_sum = {1'b0, q.sd_acc} + sd_weight(q.temp);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        dt_wrap = 1'b0;
        ct_wrap = 1'b0;

        // Two-stage synchronisers and the edge history behind them.
        d.sy1 = {ONE_WIRE_LINE_I, PACK_DETECT_IN, CONV_PULSE, SENSE_NEG, SENSE_MAG};
        d.sy2 = q.sy1;
        d.prev = {q.sy2[SY_WIRE], q.sy2[SY_PACK], q.sy2[SY_CONV]};

        // Prescaler and tick counter run in every power state.
        d.pre = tick ? '0 : q.pre + 1'b1;
        if (tick) begin
            d.tick = q.tick + 1'b1;
        end
        // The calibration strobe lasts one cycle, once per wrap of the hour tick count.
        d.cal = hour;

        // Temperature follows its source in both power states.
        d.temp = TEMP_C;

        // Converter quanta are counted only while awake.
        // A quantum that arrives asleep is dropped, so waking replays nothing stale.
        if (awake && conv_rise) begin
            if (neg) begin
                d.counts.discharge_count = q.counts.discharge_count + 1'b1;
            end else begin
                d.counts.charge_count = q.counts.charge_count + 1'b1;
            end
        end

        // Discharge time counter, fast or slow by its flag.
        if (awake && neg && nonzero) begin
            if (time_step(q.mode.discharge_timer_slow_flag, tick, slow_tick)) begin
                d.counts.discharge_time_count = dt_sum[CNT_W-1:0];
                dt_wrap = dt_sum[CNT_W];
            end
        end

        // Charge time counter, fast or slow by its flag.
        if (awake && !neg && nonzero) begin
            if (time_step(q.mode.charge_timer_slow_flag, tick, slow_tick)) begin
                d.counts.charge_time_count = ct_sum[CNT_W-1:0];
                ct_wrap = ct_sum[CNT_W];
            end
        end

        // Self-discharge accumulates weighted eighth hours, asleep too.
        // The accumulator carries fractions, so slow rates in the cold are not lost.
        if (sd_tick) begin
            d.sd_acc = sd_sum[SD_ACC_W-1:0];
            if (sd_sum[SD_ACC_W]) begin
                d.counts.self_discharge_count = q.counts.self_discharge_count + 1'b1;
            end
        end

        // Pending clears act now and sit after the increments, so a clear beats
        // a count in the same cycle; each pending bit lives one cycle and a
        // fresh strobe re-arms it.
        d.clr_pend = CLR_REQ;
        if (q.clr_pend[CLR_DISCH]) begin
            d.counts.discharge_count = '0;
        end
        if (q.clr_pend[CLR_CHG]) begin
            d.counts.charge_count = '0;
        end
        if (q.clr_pend[CLR_SELF]) begin
            d.counts.self_discharge_count = '0;
            d.sd_acc = '0;
        end
        if (q.clr_pend[CLR_DTIME]) begin
            d.counts.discharge_time_count = '0;
        end
        if (q.clr_pend[CLR_CTIME]) begin
            d.counts.charge_time_count = '0;
        end

        // Slow flags: a wrap wins over a clear in the same cycle.
        d.mode.discharge_timer_slow_flag = dt_wrap |
            (q.mode.discharge_timer_slow_flag & ~q.clr_pend[CLR_DTIME]);
        d.mode.charge_timer_slow_flag = ct_wrap |
            (q.mode.charge_timer_slow_flag & ~q.clr_pend[CLR_CTIME]);

        // Host writes of the sleep allow bit and wake threshold field.
        if (MODE_WE) begin
            d.mode.sleep_allow = SLEEP_ALLOW_WR;
            d.mode.wake_threshold_select = WAKE_SEL_WR;
        end

        // Bus inactivity counter saturates at one hour of ticks.
        // Saturating keeps the hour condition standing while the current stays high.
        if (wire_edge) begin
            d.idle = '0;
        end else if (tick && !idle_hour) begin
            d.idle = q.idle + 1'b1;
        end

        // Power state machine.
        // Pack low outranks every wake source; a fall seen asleep blocks the pack wake while sleep allow is set.
        case (q.pwr)
            PWR_AWAKE: begin
                if (!pack_high) begin
                    d.pwr = PWR_ASLEEP;
                    d.fell_asleep = 1'b0;
                end else if (idle_hour && q.mode.sleep_allow &&
                             below_thr(q.mode.wake_threshold_select, mag)) begin
                    d.pwr = PWR_ASLEEP;
                end
            end
            PWR_ASLEEP: begin
                if (pack_fall) begin
                    d.fell_asleep = 1'b1;
                end
                if (!pack_high) begin
                    d.pwr = PWR_ASLEEP;
                end else if (wire_edge) begin
                    d.pwr = PWR_AWAKE;
                end else if (pack_rise && (!q.mode.sleep_allow || !q.fell_asleep)) begin
                    d.pwr = PWR_AWAKE;
                    d.idle = '0;
                end
            end
            default: begin
                d.pwr = PWR_AWAKE;
            end
        endcase

        // Status pin sinks only when asked low and the pack is present.
        d.stat_oe = ~STAT_LEVEL & pack_high;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Reset restores counters to zero and the mode field to defaults.
    // Reset is synchronous; no process here has an asynchronous branch.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // All outputs but STAT_O come straight from the state register; STAT_O is tied low.
    // Only the enable of the status pin moves, as an open-drain driver must.
    assign COUNTS = q.counts;
    assign MODE = q.mode;
    assign CLR_PENDING = q.clr_pend;
    assign TEMPERATURE = q.temp;
    assign ASLEEP = q.pwr == PWR_ASLEEP;
    assign OFFSET_CAL = q.cal;
    assign STAT_O = 1'b0; // Open drain: only ever sinks low.
    assign STAT_OE = q.stat_oe;

endmodule

// file: verif/ccsc_checker.sv
// Concurrent checks for the coulomb counter and sleep control block.
// Bound to ccsc_top and sees only its ports.
`timescale 1ns/1ps

module ccsc_checker
    import ccsc_pkg::*;
(
    input logic CORE_CLK,
    input logic RST,
    input logic SENSE_NEG,
    input logic PACK_DETECT_IN,
    input logic [CLR_W-1:0] CLR_REQ,
    input logic MODE_WE,
    input logic SLEEP_ALLOW_WR,
    input logic [2:0] WAKE_SEL_WR,
    input ccsc_counts_t COUNTS,
    input ccsc_mode_t MODE,
    input logic [CLR_W-1:0] CLR_PENDING,
    input logic ASLEEP,
    input logic OFFSET_CAL,
    input logic STAT_OE
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // A single clear strobe, not repeated on the next cycle.
    sequence clr_once_s(int b);
        CLR_REQ[b] ##1 !CLR_REQ[b];
    endsequence

    // Pack detect seen low long enough to pass the synchronisers.
    sequence pack_low_s;
        !PACK_DETECT_IN [*3];
    endsequence

    chk_clr_pend_set: assert property (CLR_REQ[CLR_DTIME] |=> CLR_PENDING[CLR_DTIME])
        else $error("clear pending bit not raised");
    chk_clr_done: assert property (clr_once_s(CLR_DISCH) |=>
        !CLR_PENDING[CLR_DISCH] && COUNTS.discharge_count == '0)
        else $error("discharge clear not completed");
    chk_flag_clear: assert property (CLR_REQ[CLR_CTIME] ##1 (!CLR_REQ[CLR_CTIME] &&
        COUNTS.charge_time_count != 16'hffff) |=>
        !MODE.charge_timer_slow_flag && COUNTS.charge_time_count == '0)
        else $error("charge time clear left flag or count");
    chk_mode_write: assert property (MODE_WE |=> MODE.sleep_allow == $past(SLEEP_ALLOW_WR) &&
        MODE.wake_threshold_select == $past(WAKE_SEL_WR))
        else $error("mode write not taken");
    chk_wrap_flag: assert property ($rose(MODE.discharge_timer_slow_flag) |->
        COUNTS.discharge_time_count == '0)
        else $error("slow flag set without wrap");
    chk_pack_sleep: assert property (pack_low_s |=> ASLEEP && !STAT_OE)
        else $error("pack low did not force sleep");
    chk_sleep_hold: assert property (ASLEEP && CLR_REQ == '0 && CLR_PENDING == '0 |=>
        !ASLEEP || ($stable(COUNTS.discharge_count) && $stable(COUNTS.charge_count)))
        else $error("counter moved while asleep");
    chk_cal_pulse: assert property (OFFSET_CAL |=> !OFFSET_CAL)
        else $error("calibration pulse too long");
    chk_dis_step: assert property (!$stable(COUNTS.discharge_count) |->
        COUNTS.discharge_count == $past(COUNTS.discharge_count) + 16'h1 ||
        COUNTS.discharge_count == '0)
        else $error("discharge count jumped");
    chk_chg_still: assert property (SENSE_NEG [*5] |->
        $stable(COUNTS.charge_count) || COUNTS.charge_count == '0)
        else $error("charge count moved in discharge");
endmodule

bind ccsc_top ccsc_checker chk (.CORE_CLK, .RST, .SENSE_NEG, .PACK_DETECT_IN, .CLR_REQ,
    .MODE_WE, .SLEEP_ALLOW_WR, .WAKE_SEL_WR, .COUNTS, .MODE, .CLR_PENDING, .ASLEEP,
    .OFFSET_CAL, .STAT_OE);

// file: verif/ccsc_host_model.sv
// Host controller model on the single-wire bus line.
// The line has a pull-up, so it idles high between host actions.
`timescale 1ns/1ps

module ccsc_host_model (
    input logic clk,
    output logic line
);
    // Released line sits at the pulled-up level.
    initial line = 1'b1;

    // A short low pulse gives two edges; either one is bus activity.
    task automatic edge_pulse();
        @(negedge clk);
        line = 1'b0;
        repeat (4) @(negedge clk);
        line = 1'b1;
    endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the coulomb counter and sleep control block.
// Runs the timebase with a tick of 4 cycles so an hour is 16384 cycles.
`timescale 1ns/1ps

module tb_top
    import ccsc_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, design and host model
    // ------------------------------------------------------------
    logic clk = 1'b0, rst = 1'b1, conv = 1'b0, neg = 1'b0, pack = 1'b1;
    logic we = 1'b0, allow_wr = 1'b0;
    logic [2:0] mag = 3'h0, sel_wr = 3'h0;
    logic [7:0] temp = 8'h3c, tout;
    logic [4:0] clr = 5'h0;
    ccsc_counts_t counts;
    ccsc_mode_t mode;
    logic [4:0] pend;
    logic asleep, cal, stat_oe, stat_o, lvl = 1'b0;
    logic [15:0] d;
    wire line;
    int n_fail = 0, cmp_count = 0, cyc = 0, cal_n = 0, c0 = 0;

    always #5 clk = ~clk;

    ccsc_top #(.TICK_CYCLES(4)) uut (.CORE_CLK(clk), .RST(rst), .CONV_PULSE(conv),
        .SENSE_NEG(neg), .SENSE_MAG(mag), .ONE_WIRE_LINE_I(line), .PACK_DETECT_IN(pack),
        .TEMP_C(temp), .CLR_REQ(clr), .MODE_WE(we), .SLEEP_ALLOW_WR(allow_wr),
        .WAKE_SEL_WR(sel_wr), .STAT_LEVEL(lvl), .COUNTS(counts), .MODE(mode),
        .CLR_PENDING(pend), .TEMPERATURE(tout), .ASLEEP(asleep), .OFFSET_CAL(cal),
        .STAT_O(stat_o), .STAT_OE(stat_oe));

    ccsc_host_model host (.clk(clk), .line(line));

    // Counts cycles and calibration pulses; cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cal) cal_n <= cal_n + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Converter quanta, each held three cycles high and three low.
    task automatic pulse(input int n);
        repeat (n) begin
            conv = 1'b1;
            tick(3);
            conv = 1'b0;
            tick(3);
        end
    endtask

    // One-cycle clear strobe, then the pending bit rises and falls.
    task automatic do_clr(input int b);
        clr[b] = 1'b1;
        tick(1);
        clr = 5'h0;
        check(pend[b], 16'h1);
        tick(1);
        check(pend[b], 16'h0);
    endtask

    task automatic mode_wr(input logic a, input logic [2:0] s);
        we = 1'b1;
        allow_wr = a;
        sel_wr = s;
        tick(1);
        we = 1'b0;
        tick(1);
    endtask

    task automatic wait_sleep(input logic v, input int n);
        for (int i = 0; i < n && asleep !== v; i++) tick(1);
        check(asleep, v);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        rst = 1'b0;
        tick(1);
        check(mode.sleep_allow, 16'h1);
        check(mode.wake_threshold_select, 16'h7);
        check(stat_oe, 16'h1);
        check(stat_o, 16'h0);
        check(tout, 16'h3c);
        lvl = 1'b1;
        tick(1);
        check(stat_oe, 16'h0);
        lvl = 1'b0;
        tick(1);
        check(stat_oe, 16'h1);
        neg = 1'b1;
        mag = 3'h1;
        pulse(3);
        check(counts.discharge_count, 16'h3);
        check(counts.charge_count, 16'h0);
        do_clr(CLR_DTIME);
        check(counts.discharge_time_count, 16'h0);
        check(mode.discharge_timer_slow_flag, 16'h0);
        tick(40);
        check(counts.discharge_time_count inside {[9:11]}, 16'h1);
        check(counts.charge_time_count, 16'h0);
        neg = 1'b0;
        pulse(2);
        check(counts.charge_count, 16'h2);
        check(counts.discharge_count, 16'h3);
        do_clr(CLR_CTIME);
        check(mode.charge_timer_slow_flag, 16'h0);
        tick(40);
        check(counts.charge_time_count inside {[9:11]}, 16'h1);
        do_clr(CLR_DISCH);
        check(counts.discharge_count, 16'h0);
        // Every wake threshold code, ending on the default.
        for (int s = 0; s < 8; s++) begin
            mode_wr(1'b1, s[2:0]);
            check(mode.wake_threshold_select, s[2:0]);
        end
        pack = 1'b0;
        tick(4);
        check(asleep, 16'h1);
        check(stat_oe, 16'h0);
        temp = 8'h3d;
        tick(1);
        check(tout, 16'h3d);
        d = counts.charge_count;
        pulse(2);
        check(counts.charge_count, d);
        pack = 1'b1;
        wait_sleep(1'b0, 8);
        host.edge_pulse();
        // Quiet bus and no current: sleep after one hour of ticks.
        mag = 3'h0;
        d = counts.self_discharge_count;
        c0 = cal_n;
        wait_sleep(1'b1, 17000);
        check(cal_n > c0, 16'h1);
        check((counts.self_discharge_count - d) inside {[7:9]}, 16'h1);
        pack = 1'b0;
        tick(4);
        pack = 1'b1;
        tick(8);
        check(asleep, 16'h1);
        host.edge_pulse();
        check(asleep, 16'h0);
        mode_wr(1'b0, 3'h7);
        pack = 1'b0;
        tick(4);
        check(asleep, 16'h1);
        pack = 1'b1;
        wait_sleep(1'b0, 8);
        report_and_stop();
    end
endmodule
